// >>> hw/tst_secondary_thresholds.v
// Secondary noise and lid closure thresholds for fourteen touch channels.
//
// Behaviour
// - Delta above noise but not main threshold is a noise spike, skipped.
// - Noise filter off bit stops the skipping of noise spikes.
// - Noise fraction code gives 6.25, 12.5, 25 (reset) or 50 percent.
// - Noise register A: sensors 4,3,2,1 in bits 7-6,5-4,3-2,1-0.
// - Noise register B: group 7-6, sensors 7,6,5 below.
// - Delta above lid threshold sets that channel's lid status bit.
// - Lid fraction code gives 6.25, 12.5, 25 (reset) or 50 percent.
// - Lid register A: sensors 4,3,2,1 in bits 7-6,5-4,3-2,1-0.
// - Lid register B: sensors 8,7,6,5 in bits 7-6,5-4,3-2,1-0.
// - Lid register C: sensors 12,11,10,9 in bits 7-6 down to 1-0.
// - Lid register D: sensors 14, 13 in bits 3-2, 1-0; reset 0Ah.
// - Main thresholds are 7-bit, reset 40h; touch when delta exceeds.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "tst_consts.vh"
module tst_secondary_thresholds (
    input  wire                              ref_clk,
    input  wire                              sys_rst,
    input  wire [7:0]                        regAddr,
    input  wire [7:0]                        regWdata,
    input  wire                              regWrite,
    input  wire                              regRead,
    output reg  [7:0]                        regRdata,
    input  wire                              sampleValid,
    input  wire [`TST_NCHAN*`TST_DELTA_W-1:0] deltaBus,
    output reg  [`TST_NCHAN-1:0]             touchOut,
    output reg  [`TST_NCHAN-1:0]             noiseSpike,
    output reg  [`TST_NCHAN-1:0]             recalUse,
    output reg                               sampleDone,
    output wire                              irqOut
);
    // Configuration registers.
    reg  [7:0]            noiseA_q;
    reg  [7:0]            noiseB_q;
    reg  [7:0]            lidA_q;
    reg  [7:0]            lidB_q;
    reg  [7:0]            lidC_q;
    reg  [7:0]            lidD_q;
    reg  [7:0]            ctrl_q;
    reg  [`TST_TH_W-1:0]  mainTh_q [0:`TST_NMAIN-1];
    // Sticky status: lid closure per channel, and interrupt events.
    reg  [`TST_NCHAN-1:0] lidStat_q;
    reg  [`TST_NCHAN-1:0] irqStat_q;
    reg  [`TST_NCHAN-1:0] irqMask_q;

    wire [`TST_NCHAN*`TST_FRAC_W-1:0] noiseFracBus;
    wire [`TST_NCHAN*`TST_FRAC_W-1:0] lidFracBus;
    wire [`TST_NCHAN-1:0]             touchHit;
    wire [`TST_NCHAN-1:0]             noiseHit;
    wire [`TST_NCHAN-1:0]             lidHit;
    wire                              noiseOff;

    // The grouped sensors 8-14 all share one noise fraction and the group
    // main threshold; sensors 1-7 each have their own.
    assign noiseFracBus = {{(`TST_NCHAN-`TST_GROUP_FIRST){noiseB_q[7:6]}},
                           noiseB_q[5:0], noiseA_q};
    assign lidFracBus   = {lidD_q[3:0], lidC_q, lidB_q, lidA_q};
    assign noiseOff     = ctrl_q[`TST_CTRL_NOISE_OFF];

    // One comparator set per channel.
    genvar gi;
    generate
        for (gi = 0; gi < `TST_NCHAN; gi = gi + 1) begin : gChan
            tst_chan_compare uCmp (
                .delta     (deltaBus[gi*`TST_DELTA_W +: `TST_DELTA_W]),
                .mainTh    (mainTh_q[(gi < `TST_GROUP_FIRST) ? gi
                                     : `TST_NMAIN-1]),
                .noiseFrac (noiseFracBus[gi*`TST_FRAC_W +: `TST_FRAC_W]),
                .lidFrac   (lidFracBus[gi*`TST_FRAC_W +: `TST_FRAC_W]),
                .touchHit  (touchHit[gi]),
                .noiseHit  (noiseHit[gi]),
                .lidHit    (lidHit[gi])
            );
        end
    endgenerate

    // Write-one-to-clear masks for the sticky registers.
    wire [`TST_NCHAN-1:0] lidClr;
    wire [`TST_NCHAN-1:0] irqClr;
    wire [`TST_NCHAN-1:0] lidSet;
    assign lidClr = {
        (regWrite && regAddr == `TST_LID_STAT1_ADDR) ? regWdata[6:0] : 7'h00,
        (regWrite && regAddr == `TST_LID_STAT0_ADDR) ? regWdata[6:0] : 7'h00};
    assign irqClr = {
        (regWrite && regAddr == `TST_IRQ_STAT1_ADDR) ? regWdata[6:0] : 7'h00,
        (regWrite && regAddr == `TST_IRQ_STAT0_ADDR) ? regWdata[6:0] : 7'h00};
    assign lidSet = sampleValid ? lidHit : {`TST_NCHAN{1'b0}};

    // Register writes; unmapped addresses are ignored.
    integer i;
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            noiseA_q <= `TST_NOISE_RST;
            noiseB_q <= `TST_NOISE_RST;
            lidA_q   <= `TST_LID_RST;
            lidB_q   <= `TST_LID_RST;
            lidC_q   <= `TST_LID_RST;
            lidD_q   <= `TST_LID_D_RST;
            ctrl_q   <= `TST_CTRL_RST;
            for (i = 0; i < `TST_NMAIN; i = i + 1) begin
                mainTh_q[i] <= `TST_MAIN_TH_RST;
            end
        end else if (regWrite) begin
            if (regAddr == `TST_NOISE_A_ADDR) begin
                noiseA_q <= regWdata;
            end else if (regAddr == `TST_NOISE_B_ADDR) begin
                noiseB_q <= regWdata;
            end else if (regAddr == `TST_LID_A_ADDR) begin
                lidA_q <= regWdata;
            end else if (regAddr == `TST_LID_B_ADDR) begin
                lidB_q <= regWdata;
            end else if (regAddr == `TST_LID_C_ADDR) begin
                lidC_q <= regWdata;
            end else if (regAddr == `TST_LID_D_ADDR) begin
                lidD_q <= regWdata & `TST_LID_D_MASK;
            end else if (regAddr == `TST_CTRL_ADDR) begin
                ctrl_q <= regWdata;
            end else if (regAddr >= `TST_MAIN_TH_BASE &&
                         regAddr <= `TST_MAIN_TH_LAST) begin
                mainTh_q[regAddr[2:0]] <= regWdata[6:0];
            end
        end
    end

    // Sticky status; a set in the same cycle as its clear wins, so an
    // event is never lost to a racing software clear.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            lidStat_q <= {`TST_NCHAN{1'b0}};
            irqStat_q <= {`TST_NCHAN{1'b0}};
            irqMask_q <= {`TST_NCHAN{1'b0}};
        end else begin
            lidStat_q <= (lidStat_q & ~lidClr) | lidSet;
            irqStat_q <= (irqStat_q & ~irqClr) | lidSet;
            if (regWrite && regAddr == `TST_IRQ_MASK0_ADDR) begin
                irqMask_q[6:0] <= regWdata[6:0];
            end else if (regWrite && regAddr == `TST_IRQ_MASK1_ADDR) begin
                irqMask_q[13:7] <= regWdata[6:0];
            end
        end
    end

    // Level interrupt: any unmasked lid event pending.
    assign irqOut = |(irqStat_q & irqMask_q);

    // Per-sample classification, registered one cycle after sampleValid.
    // Noise spikes leave recalibration averaging unless filtering is off.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            touchOut   <= {`TST_NCHAN{1'b0}};
            noiseSpike <= {`TST_NCHAN{1'b0}};
            recalUse   <= {`TST_NCHAN{1'b0}};
            sampleDone <= 1'b0;
        end else begin
            sampleDone <= sampleValid;
            if (sampleValid) begin
                touchOut   <= touchHit;
                noiseSpike <= noiseHit;
                recalUse   <= noiseOff ? {`TST_NCHAN{1'b1}}
                                       : ~noiseHit;
            end
        end
    end

    // Read data, valid in the cycle after the read strobe; unmapped reads 0.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            if (regAddr == `TST_NOISE_A_ADDR) begin
                regRdata <= noiseA_q;
            end else if (regAddr == `TST_NOISE_B_ADDR) begin
                regRdata <= noiseB_q;
            end else if (regAddr == `TST_LID_A_ADDR) begin
                regRdata <= lidA_q;
            end else if (regAddr == `TST_LID_B_ADDR) begin
                regRdata <= lidB_q;
            end else if (regAddr == `TST_LID_C_ADDR) begin
                regRdata <= lidC_q;
            end else if (regAddr == `TST_LID_D_ADDR) begin
                regRdata <= lidD_q;
            end else if (regAddr == `TST_CTRL_ADDR) begin
                regRdata <= ctrl_q;
            end else if (regAddr == `TST_LID_STAT0_ADDR) begin
                regRdata <= {1'b0, lidStat_q[6:0]};
            end else if (regAddr == `TST_LID_STAT1_ADDR) begin
                regRdata <= {1'b0, lidStat_q[13:7]};
            end else if (regAddr == `TST_IRQ_STAT0_ADDR) begin
                regRdata <= {1'b0, irqStat_q[6:0]};
            end else if (regAddr == `TST_IRQ_STAT1_ADDR) begin
                regRdata <= {1'b0, irqStat_q[13:7]};
            end else if (regAddr == `TST_IRQ_MASK0_ADDR) begin
                regRdata <= {1'b0, irqMask_q[6:0]};
            end else if (regAddr == `TST_IRQ_MASK1_ADDR) begin
                regRdata <= {1'b0, irqMask_q[13:7]};
            end else if (regAddr >= `TST_MAIN_TH_BASE &&
                         regAddr <= `TST_MAIN_TH_LAST) begin
                regRdata <= {1'b0, mainTh_q[regAddr[2:0]]};
            end else begin
                regRdata <= 8'h00;
            end
        end else begin
            regRdata <= 8'h00;
        end
    end
endmodule

// >>> hw/tst_consts.vh
// Register offsets, field layouts and reset values for the secondary thresholds.
`ifndef TST_CONSTS_VH
`define TST_CONSTS_VH
`define TST_NOISE_A_ADDR   8'h38
`define TST_NOISE_B_ADDR   8'h39
`define TST_LID_A_ADDR     8'h3A
`define TST_LID_B_ADDR     8'h3B
`define TST_LID_C_ADDR     8'h3C
`define TST_LID_D_ADDR     8'h3D
`define TST_MAIN_TH_BASE   8'h30
`define TST_MAIN_TH_LAST   8'h37
`define TST_CTRL_ADDR      8'h40
`define TST_LID_STAT0_ADDR 8'h41
`define TST_LID_STAT1_ADDR 8'h42
`define TST_IRQ_STAT0_ADDR 8'h43
`define TST_IRQ_STAT1_ADDR 8'h44
`define TST_IRQ_MASK0_ADDR 8'h45
`define TST_IRQ_MASK1_ADDR 8'h46
`define TST_NOISE_RST      8'hAA
`define TST_LID_RST        8'hAA
`define TST_LID_D_RST      8'h0A
`define TST_LID_D_MASK     8'h0F
`define TST_MAIN_TH_RST    7'h40
`define TST_CTRL_RST       8'h00
`define TST_CTRL_NOISE_OFF 0
`define TST_NCHAN          14
`define TST_NMAIN          8
`define TST_GROUP_FIRST    7
`define TST_FRAC_W         2
`define TST_TH_W           7
`define TST_DELTA_W        8
`endif

// >>> hw/tst_frac_scale.v
// Scales a main threshold by a 2-bit fraction code.
`timescale 1ns/1ps
`include "tst_consts.vh"
module tst_frac_scale (
    input  wire [`TST_TH_W-1:0]   mainTh,
    input  wire [`TST_FRAC_W-1:0] fracCode,
    output reg  [`TST_TH_W-1:0]   derivedTh
);
    // Codes 00..11 shift by 4, 3, 2, 1 (6.25%, 12.5%, 25%, 50%).
    always @* begin
        case (fracCode)
            2'h0: derivedTh = mainTh >> 4;
            2'h1: derivedTh = mainTh >> 3;
            2'h2: derivedTh = mainTh >> 2;
            default: derivedTh = mainTh >> 1;
        endcase
    end
endmodule

// >>> hw/tst_chan_compare.v
// Per-channel comparison of a delta against main, noise and lid thresholds.
`timescale 1ns/1ps
`include "tst_consts.vh"
module tst_chan_compare (
    input  wire [`TST_DELTA_W-1:0] delta,
    input  wire [`TST_TH_W-1:0]    mainTh,
    input  wire [`TST_FRAC_W-1:0]  noiseFrac,
    input  wire [`TST_FRAC_W-1:0]  lidFrac,
    output wire                    touchHit,
    output wire                    noiseHit,
    output wire                    lidHit
);
    wire [`TST_TH_W-1:0] noiseTh;
    wire [`TST_TH_W-1:0] lidTh;

    tst_frac_scale uNoise (
        .mainTh    (mainTh),
        .fracCode  (noiseFrac),
        .derivedTh (noiseTh)
    );
    tst_frac_scale uLid (
        .mainTh    (mainTh),
        .fracCode  (lidFrac),
        .derivedTh (lidTh)
    );

    // Strict greater-than: equal to a threshold is not exceeding it.
    assign touchHit = delta > {1'b0, mainTh};
    assign noiseHit = (delta > {1'b0, noiseTh}) && !touchHit;
    assign lidHit   = delta > {1'b0, lidTh};
endmodule

// >>> tb/tst_st_asserts.sv
// Port-level checker for the secondary threshold block.
`timescale 1ns/1ps
`include "tst_consts.vh"
module tst_st_asserts (
    input logic        ref_clk,
    input logic        sys_rst,
    input logic [7:0]  regAddr,
    input logic [7:0]  regWdata,
    input logic        regWrite,
    input logic        regRead,
    input logic [7:0]  regRdata,
    input logic        sampleValid,
    input logic [13:0] touchOut,
    input logic [13:0] noiseSpike,
    input logic [13:0] recalUse,
    input logic        sampleDone
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // A fraction write followed by a read of the same place returns it.
    sequence sWrRd;
        regWrite && regAddr >= 8'h38 && regAddr <= 8'h3C ##1
            regRead && $stable(regAddr);
    endsequence
    property pWrRd;
        sWrRd |=> regRdata == $past(regWdata, 2);
    endproperty

    AST_DONE: assert property (sampleValid |=> sampleDone)
        else $error("sample not answered");
    AST_NO_DONE: assert property (!sampleValid |=> !sampleDone)
        else $error("done without sample");
    AST_SPIKE: assert property (
        sampleDone |-> !(|(noiseSpike & touchOut)))
        else $error("spike on touched channel");
    AST_RECAL: assert property (
        sampleDone |-> &(recalUse | noiseSpike))
        else $error("clean sample kept from averaging");
    AST_HOLD: assert property (!sampleValid |=> $stable(touchOut)
        && $stable(noiseSpike) && $stable(recalUse))
        else $error("class outputs moved without sample");
    AST_RD_IDLE: assert property (
        !regRead |=> regRdata == 8'h00)
        else $error("read data outside read slot");
    AST_LID_D: assert property (
        regRead && regAddr == `TST_LID_D_ADDR |=> regRdata[7:4] == 4'h0)
        else $error("unused lid bits read back set");
    AST_WR_RD: assert property (pWrRd)
        else $error("fraction register lost write");
endmodule

bind tst_secondary_thresholds tst_st_asserts tst_st_asserts_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .sampleValid(sampleValid), .touchOut(touchOut),
    .noiseSpike(noiseSpike), .recalUse(recalUse), .sampleDone(sampleDone));

// >>> tb/test_tst_secondary_thresholds.sv
// Self-checking bench for the secondary threshold block.
`timescale 1ns/1ps
`include "tst_consts.vh"
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin \
    errTotal++; $display("wrong value at %0t: %h expected %h", \
    $time, a, b); end end
module test_tst_secondary_thresholds;
    logic         ref_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic [7:0]   regAddr = 8'h00;
    logic [7:0]   regWdata = 8'h00;
    logic [7:0]   rv;
    logic         regWrite = 1'b0;
    logic         regRead = 1'b0;
    logic         sampleValid = 1'b0;
    logic [111:0] deltaBus = '0;
    wire  [7:0]   regRdata;
    wire  [13:0]  touchOut, noiseSpike, recalUse;
    wire          sampleDone, irqOut;
    int           errTotal = 0, samplesChecked = 0, cycles = 0;

    tst_secondary_thresholds tst_secondary_thresholds_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .sampleValid(sampleValid), .deltaBus(deltaBus),
        .touchOut(touchOut), .noiseSpike(noiseSpike), .recalUse(recalUse),
        .sampleDone(sampleDone), .irqOut(irqOut));

    // Clock at 125 MHz.
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    // Cuts a hang short; the whole run needs well under this.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errTotal++;
            results();
        end
    end

    task automatic results();
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Bus tasks keep each strobe to a single cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1; regAddr <= a; regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        regRead <= 1'b1; regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 rv = regRdata;
    endtask
    task automatic smp(input logic [111:0] d);
        @(posedge ref_clk);
        sampleValid <= 1'b1; deltaBus <= d;
        @(posedge ref_clk);
        sampleValid <= 1'b0;
        #1 `CHK(sampleDone, 1'b1)
    endtask

    task automatic resetValues();
        logic [7:0] ex [6] = '{8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'h0A};
        for (int i = 0; i < 6; i++) begin
            rd(8'h38 + 8'(i));
            `CHK(rv, ex[i])
        end
        rd(`TST_MAIN_TH_BASE);
        `CHK(rv, 8'h40)
        rd(8'h50);
        `CHK(rv, 8'h00)
    endtask
    // Distinct codes per sensor expose both decode and field placement.
    task automatic noiseA();
        logic [7:0] dl [5] = '{8'h08, 8'h09, 8'h11, 8'h21, 8'h41};
        logic [3:0] ex [5] = '{4'h1, 4'h3, 4'h7, 4'hF, 4'h0};
        wr(`TST_NOISE_A_ADDR, 8'hE4);
        for (int i = 0; i < 5; i++) begin
            smp({80'h0, {4{dl[i]}}});
            `CHK(noiseSpike[3:0], ex[i])
            `CHK(recalUse[3:0], ~ex[i])
        end
        `CHK(touchOut[3:0], 4'hF)
    endtask
    task automatic noiseB();
        wr(`TST_NOISE_B_ADDR, 8'h39);
        smp({14{8'h09}});
        `CHK(noiseSpike[13:4], 10'h3F9)
    endtask
    task automatic filterOff();
        wr(`TST_CTRL_ADDR, 8'h01);
        smp({14{8'h09}});
        `CHK(recalUse, 14'h3FFF)
        wr(`TST_CTRL_ADDR, 8'h00);
    endtask
    task automatic lidAndIrq();
        wr(`TST_LID_A_ADDR, 8'hE4);
        wr(`TST_LID_B_ADDR, 8'hE4);
        wr(`TST_LID_C_ADDR, 8'hE4);
        wr(`TST_LID_D_ADDR, 8'hF4);
        rd(`TST_LID_D_ADDR);
        `CHK(rv, 8'h04)
        wr(`TST_LID_STAT0_ADDR, 8'h7F);
        wr(`TST_LID_STAT1_ADDR, 8'h7F);
        smp({14{8'h09}});
        rd(`TST_LID_STAT0_ADDR);
        `CHK(rv, 8'h33)
        rd(`TST_LID_STAT1_ADDR);
        `CHK(rv, 8'h66)
        wr(`TST_IRQ_MASK0_ADDR, 8'h01);
        #1 `CHK(irqOut, 1'b1)
        wr(`TST_IRQ_STAT0_ADDR, 8'h01);
        #1 `CHK(irqOut, 1'b0)
        wr(`TST_IRQ_MASK0_ADDR, 8'h02);
        #1 `CHK(irqOut, 1'b1)
        wr(`TST_IRQ_MASK0_ADDR, 8'h00);
        #1 `CHK(irqOut, 1'b0)
    endtask
    // Write strobe and read strobe back to back, with no idle cycle.
    task automatic backToBack();
        @(posedge ref_clk);
        regWrite <= 1'b1; regAddr <= `TST_LID_A_ADDR; regWdata <= 8'h5A;
        @(posedge ref_clk);
        regWrite <= 1'b0; regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 `CHK(regRdata, 8'h5A)
    endtask
    // A second reset must restore the defaults mid-run.
    task automatic midReset();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`TST_LID_A_ADDR);
        `CHK(rv, 8'hAA)
        `CHK(noiseSpike, 14'h0000)
    endtask

    // Main sequence.
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        resetValues();
        noiseA();
        noiseB();
        filterOff();
        lidAndIrq();
        backToBack();
        midReset();
        results();
    end
endmodule
